// ### src/alc_pkg.sv
// package for the async line configuration block
// assumes a 32-bit avalon-mm slave with word addresses in bytes
package alc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_LINE_FMT = 6'h00; // line format also when open
  localparam logic [5:0] OFF_TX_MODE = 6'h04;  // divisor a low when open
  localparam logic [5:0] OFF_FIFO_THR = 6'h08; // divisor a high when open
  localparam logic [5:0] OFF_MATCH0 = 6'h0C;   // divisor b low when open
  localparam logic [5:0] OFF_MATCH1 = 6'h10;
  localparam logic [5:0] OFF_RX_MODE = 6'h14;
  localparam logic [5:0] OFF_CLK_SEL = 6'h18;
  localparam logic [5:0] OFF_MODE = 6'h1C;     // loop, echo mode, ulan
  localparam logic [5:0] OFF_STATUS = 6'h20;   // read; a write of bit 3 sets the rx lock in ulan mode

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FMT = 8'h03;      // 8 bits, no parity
  localparam logic [7:0] RST_DIV_LO = 8'h05;
  localparam logic [7:0] RST_DIV_HI = 8'h00;

  // ----------------------------------------------------------------
  // line format fields
  // ----------------------------------------------------------------
  localparam int FMT_DIV_ACC = 7;
  localparam int FMT_BREAK = 6;
  localparam int FMT_PAR_HI = 5;
  localparam int FMT_PAR_LO = 4;
  localparam int FMT_PAR_EN = 3;
  localparam int FMT_STOP_B0 = 2;
  localparam int FMT_CL_B1 = 1;
  localparam int FMT_CL_B0 = 0;
  // tx mode fields
  localparam int TMD_ERR_ECHO_OFF = 7;
  localparam int TMD_CTRL_ECHO_OFF = 6;
  localparam int TMD_NINE = 5;
  localparam int TMD_FLOW_HI = 4;
  localparam int TMD_FLOW_LO = 3;
  localparam int TMD_SOFT_PAR = 2;
  localparam int TMD_STOP_B2 = 1;
  localparam int TMD_STOP_B1 = 0;
  // rx mode fields
  localparam int RMD_RECOG_HI = 7;
  localparam int RMD_RECOG_LO = 6;
  localparam int RMD_PHASE_OFF = 5;
  localparam int RMD_WINDOW = 4;
  localparam int RMD_START = 3;
  // clock select fields
  localparam int CLK_RX_MODE = 7;
  localparam int CLK_RX_SRC = 6;
  localparam int CLK_TX_MODE = 5;
  localparam int CLK_TX_SRC = 4;
  // mode register fields
  localparam int MODE_LOOP_CTL = 2;
  localparam int MODE_LOOP_ECHO = 1;
  localparam int MODE_ULAN = 0;

  // ----------------------------------------------------------------
  // character constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ASCII_CTRL_TOP = 8'h1F;
  localparam logic [7:0] ASCII_DEL = 8'h7F;
  localparam logic [7:0] EBCDIC_CTRL_TOP = 8'h3F;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // ----------------------------------------------------------------
  // decoded encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALC_PAR_NONE, ALC_PAR_ODD, ALC_PAR_EVEN, ALC_PAR_MARK, ALC_PAR_SPACE,
    ALC_PAR_SOFT, ALC_PAR_RSVD
  } alc_parity_t;

  typedef enum logic [1:0] {
    ALC_FLOW_MANUAL, ALC_FLOW_RSVD, ALC_FLOW_SEMI, ALC_FLOW_AUTO
  } alc_flow_t;

  typedef enum logic [1:0] {
    ALC_LOOP_NONE, ALC_LOOP_LOCAL, ALC_LOOP_REMOTE, ALC_LOOP_ECHO
  } alc_loop_t;

  // decoded line format handed to the tx/rx machines
  typedef struct packed {
    alc_parity_t parity;
    logic [3:0] char_bits;      // 5..9
    logic [3:0] stop_quarters;  // stop length in quarter bits, 16x
    logic force_break;
  } alc_line_t;

  // receive sampling and clock options
  typedef struct packed {
    logic phase_track_off;
    logic wide_window;          // 0: 3/16 window, 1: 7/16 window
    logic strict_start;         // 0: majority vote, 1: all samples zero
    logic rx_clk_1x;
    logic rx_use_gen_a;
    logic tx_clk_1x;
    logic tx_use_gen_a;
  } alc_samp_t;

  // one received character from the rx machine
  typedef struct packed {
    logic valid;
    logic [8:0] data;           // bit 8 is the address bit in ulan mode
    logic error;
  } alc_rx_char_t;

endpackage

// ### src/alc_config.sv
// configuration logic of an asynchronous serial controller
// assumes the tx/rx machines, fifos and baud generators live outside
// and that software writes the configuration only while the line is idle
module alc_config #(
  parameter int FIFO_DEPTH = 4,
  parameter int OCC_W = 3
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // transmit side status and pins
  input wire logic tx_enabled_in,
  input wire logic tx_more_data_in,
  input wire logic tx_serial_in,
  input wire logic cts_n_in,
  input wire logic host_rts_n_in,
  output logic tx_pin_out,
  output logic rts_n_out,
  output logic tx_go_out,
  // fifo occupancy and requests
  input wire logic [OCC_W-1:0] rx_occupancy_in,
  input wire logic [OCC_W-1:0] tx_occupancy_in,
  output logic rx_fifo_req_out,
  output logic tx_fifo_req_out,
  // received characters and recognition results
  input alc_pkg::alc_rx_char_t rx_char_in,
  output logic rx_fifo_write_out,
  output logic echo_char_out,
  output logic rx_fifo_locked_out,
  // decoded configuration
  output alc_pkg::alc_line_t line_cfg_out,
  output alc_pkg::alc_samp_t samp_cfg_out,
  output alc_pkg::alc_loop_t loop_mode_out,
  output logic [15:0] gen_a_divisor_out,
  output logic [15:0] gen_b_divisor_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] line_format_config_r;
  logic [7:0] tx_machine_mode_r;
  logic [7:0] fifo_threshold_config_r;
  logic [7:0] match_char_0_r;
  logic [7:0] match_char_1_r;
  logic [7:0] rx_machine_mode_r;
  logic [7:0] serial_clock_select_r;
  logic [7:0] mode_r;
  logic [7:0] gen_a_div_low_r;
  logic [7:0] gen_a_div_high_r;
  logic [7:0] gen_b_div_low_r;
  logic [7:0] gen_b_div_high_r;
  logic programmed_match_flag_r;
  logic char_recognized_flag_r;
  logic rx_locked_r;
  logic ack_r;
  logic [31:0] rdata_r;

  logic access;
  logic wr_go;
  logic rd_go;
  logic div_open;
  logic [7:0] wbyte;
  logic status_rd;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait cycle per access so read data can come from a flop
  assign access = (avs_read_in | avs_write_in) & clk_en_in;
  assign avs_waitrequest_out = ~(ack_r & clk_en_in);
  assign wr_go = avs_write_in & ack_r & clk_en_in & avs_byteenable_in[0];
  assign rd_go = avs_read_in & ~ack_r & clk_en_in;
  assign wbyte = avs_writedata_in[7:0];
  assign div_open = line_format_config_r[alc_pkg::FMT_DIV_ACC];
  assign status_rd = avs_read_in & ack_r & clk_en_in &
                     (avs_address_in == alc_pkg::OFF_STATUS);

  // ack toggles high for one cycle per request
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
    end else if (clk_en_in) begin
      ack_r <= access & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // config writes are taken at any time; software keeps them idle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_format_config_r <= alc_pkg::RST_FMT;
      tx_machine_mode_r <= alc_pkg::RST_ZERO;
      fifo_threshold_config_r <= alc_pkg::RST_ZERO;
      match_char_0_r <= alc_pkg::RST_ZERO;
      match_char_1_r <= alc_pkg::RST_ZERO;
      rx_machine_mode_r <= alc_pkg::RST_ZERO;
      serial_clock_select_r <= alc_pkg::RST_ZERO;
      mode_r <= alc_pkg::RST_ZERO;
    end else if (wr_go) begin
      case (avs_address_in)
        alc_pkg::OFF_LINE_FMT: line_format_config_r <= wbyte;
        alc_pkg::OFF_TX_MODE:
          if (!div_open) tx_machine_mode_r <= wbyte;
        alc_pkg::OFF_FIFO_THR:
          if (!div_open) fifo_threshold_config_r <= wbyte;
        alc_pkg::OFF_MATCH0:
          if (!div_open) match_char_0_r <= wbyte;
        alc_pkg::OFF_MATCH1:
          if (!div_open) match_char_1_r <= wbyte;
        alc_pkg::OFF_RX_MODE: rx_machine_mode_r <= wbyte;
        alc_pkg::OFF_CLK_SEL: serial_clock_select_r <= wbyte;
        alc_pkg::OFF_MODE: mode_r <= wbyte;
        default: ;
      endcase
    end
  end

  // divisor bytes share offsets while divisor_access is set
  // line format stays reachable so software can close the window again
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_a_div_low_r <= alc_pkg::RST_DIV_LO;
      gen_a_div_high_r <= alc_pkg::RST_DIV_HI;
      gen_b_div_low_r <= alc_pkg::RST_DIV_LO;
      gen_b_div_high_r <= alc_pkg::RST_DIV_HI;
    end else if (wr_go && div_open) begin
      case (avs_address_in)
        alc_pkg::OFF_TX_MODE: gen_a_div_low_r <= wbyte;
        alc_pkg::OFF_FIFO_THR: gen_a_div_high_r <= wbyte;
        alc_pkg::OFF_MATCH0: gen_b_div_low_r <= wbyte;
        alc_pkg::OFF_MATCH1: gen_b_div_high_r <= wbyte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= alc_pkg::UNMAPPED_DATA;
    end else if (rd_go) begin
      rdata_r <= alc_pkg::UNMAPPED_DATA;
      case (avs_address_in)
        alc_pkg::OFF_LINE_FMT: rdata_r[7:0] <= line_format_config_r;
        alc_pkg::OFF_TX_MODE:
          rdata_r[7:0] <= div_open ? gen_a_div_low_r
                                   : tx_machine_mode_r;
        alc_pkg::OFF_FIFO_THR:
          rdata_r[7:0] <= div_open ? gen_a_div_high_r
                                   : fifo_threshold_config_r;
        alc_pkg::OFF_MATCH0:
          rdata_r[7:0] <= div_open ? gen_b_div_low_r : match_char_0_r;
        alc_pkg::OFF_MATCH1:
          rdata_r[7:0] <= div_open ? gen_b_div_high_r : match_char_1_r;
        alc_pkg::OFF_RX_MODE: rdata_r[7:0] <= rx_machine_mode_r;
        alc_pkg::OFF_CLK_SEL: rdata_r[7:0] <= serial_clock_select_r;
        alc_pkg::OFF_MODE: rdata_r[7:0] <= mode_r;
        alc_pkg::OFF_STATUS:
          rdata_r[3:0] <= {rx_locked_r, rx_fifo_req_out,
                           programmed_match_flag_r,
                           char_recognized_flag_r};
        default: ;
      endcase
    end
  end
  assign avs_readdata_out = rdata_r;

  // ----------------------------------------------------------------
  // line format decode
  // ----------------------------------------------------------------
  logic [2:0] stop_code;
  logic [2:0] len_code;
  logic [3:0] par_code;
  logic [1:0] flow_code;

  assign stop_code = {tx_machine_mode_r[alc_pkg::TMD_STOP_B2],
                      tx_machine_mode_r[alc_pkg::TMD_STOP_B1],
                      line_format_config_r[alc_pkg::FMT_STOP_B0]};
  assign len_code = {tx_machine_mode_r[alc_pkg::TMD_NINE],
                     line_format_config_r[alc_pkg::FMT_CL_B1],
                     line_format_config_r[alc_pkg::FMT_CL_B0]};
  assign par_code = {line_format_config_r[alc_pkg::FMT_PAR_EN],
                     tx_machine_mode_r[alc_pkg::TMD_SOFT_PAR],
                     line_format_config_r[alc_pkg::FMT_PAR_HI],
                     line_format_config_r[alc_pkg::FMT_PAR_LO]};
  assign flow_code = {tx_machine_mode_r[alc_pkg::TMD_FLOW_HI],
                      tx_machine_mode_r[alc_pkg::TMD_FLOW_LO]};

  // character size, parity and stop length for the machines
  always_comb begin
    line_cfg_out.force_break = line_format_config_r[alc_pkg::FMT_BREAK];
    case (len_code)
      3'b000: line_cfg_out.char_bits = 4'h5;
      3'b001: line_cfg_out.char_bits = 4'h6;
      3'b010: line_cfg_out.char_bits = 4'h7;
      3'b011: line_cfg_out.char_bits = 4'h8;
      default: line_cfg_out.char_bits = 4'h9; // only 100 is legal
    endcase
    case (stop_code) // stop length in quarter bits
      3'b000: line_cfg_out.stop_quarters = 4'h4;
      3'b001: line_cfg_out.stop_quarters = (len_code == 3'b000) ? 4'h6
                                                                : 4'h8;
      3'b010: line_cfg_out.stop_quarters = 4'h3;
      3'b011: line_cfg_out.stop_quarters = 4'h4;
      3'b100: line_cfg_out.stop_quarters = 4'h5;
      3'b101: line_cfg_out.stop_quarters = 4'h6;
      3'b110: line_cfg_out.stop_quarters = 4'h7;
      default: line_cfg_out.stop_quarters = 4'h8;
    endcase
    // soft parity leaves bit generation and checking to the host
    casez (par_code)
      4'b0???: line_cfg_out.parity = alc_pkg::ALC_PAR_NONE;
      4'b1000: line_cfg_out.parity = alc_pkg::ALC_PAR_ODD;
      4'b1001: line_cfg_out.parity = alc_pkg::ALC_PAR_EVEN;
      4'b1010: line_cfg_out.parity = alc_pkg::ALC_PAR_MARK;
      4'b1011: line_cfg_out.parity = alc_pkg::ALC_PAR_SPACE;
      4'b1100: line_cfg_out.parity = alc_pkg::ALC_PAR_SOFT;
      default: line_cfg_out.parity = alc_pkg::ALC_PAR_RSVD;
    endcase
  end

  // ----------------------------------------------------------------
  // sampling, clocks, loop and echo
  // ----------------------------------------------------------------
  always_comb begin
    samp_cfg_out.phase_track_off =
      rx_machine_mode_r[alc_pkg::RMD_PHASE_OFF];
    samp_cfg_out.wide_window = rx_machine_mode_r[alc_pkg::RMD_WINDOW];
    samp_cfg_out.strict_start = rx_machine_mode_r[alc_pkg::RMD_START];
    samp_cfg_out.rx_clk_1x = serial_clock_select_r[alc_pkg::CLK_RX_MODE];
    samp_cfg_out.rx_use_gen_a =
      serial_clock_select_r[alc_pkg::CLK_RX_SRC];
    samp_cfg_out.tx_clk_1x = serial_clock_select_r[alc_pkg::CLK_TX_MODE];
    samp_cfg_out.tx_use_gen_a =
      serial_clock_select_r[alc_pkg::CLK_TX_SRC];
  end

  // one bit chooses loopback flavour or echo on/off
  always_comb begin
    case ({mode_r[alc_pkg::MODE_LOOP_CTL], mode_r[alc_pkg::MODE_LOOP_ECHO]})
      2'b10: loop_mode_out = alc_pkg::ALC_LOOP_LOCAL;
      2'b11: loop_mode_out = alc_pkg::ALC_LOOP_REMOTE;
      2'b01: loop_mode_out = alc_pkg::ALC_LOOP_ECHO;
      default: loop_mode_out = alc_pkg::ALC_LOOP_NONE;
    endcase
  end

  assign gen_a_divisor_out = {gen_a_div_high_r, gen_a_div_low_r};
  assign gen_b_divisor_out = {gen_b_div_high_r, gen_b_div_low_r};

  // ----------------------------------------------------------------
  // transmit pin and flow control
  // ----------------------------------------------------------------
  logic cts_ok;
  assign cts_ok = ~cts_n_in;

  // break overrides any transmitter activity
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pin_out <= 1'b1;
    end else if (clk_en_in) begin
      tx_pin_out <= line_cfg_out.force_break ? 1'b0 : tx_serial_in;
    end
  end

  // manual mode passes host control through untouched
  always_comb begin
    case (flow_code)
      2'b10: begin
        tx_go_out = tx_enabled_in & cts_ok;
        rts_n_out = ~tx_enabled_in;
      end
      2'b11: begin
        tx_go_out = tx_enabled_in & cts_ok;
        rts_n_out = ~(tx_enabled_in & tx_more_data_in);
      end
      default: begin
        tx_go_out = tx_enabled_in;
        rts_n_out = host_rts_n_in;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // fifo requests
  // ----------------------------------------------------------------
  logic [OCC_W-1:0] rx_thr;
  logic [OCC_W-1:0] tx_thr;
  assign rx_thr = OCC_W'(fifo_threshold_config_r[5:4]);
  assign tx_thr = OCC_W'(fifo_threshold_config_r[1:0]);
  assign rx_fifo_req_out = rx_occupancy_in > rx_thr;
  assign tx_fifo_req_out = tx_occupancy_in <= tx_thr;

  // ----------------------------------------------------------------
  // character recognition
  // ----------------------------------------------------------------
  logic ulan;
  logic [1:0] recog;
  logic [7:0] ch;
  logic is_addr;
  logic prog_hit;
  logic std_hit;
  logic recog_hit;
  logic match_hit;

  assign ulan = mode_r[alc_pkg::MODE_ULAN];
  assign recog = {rx_machine_mode_r[alc_pkg::RMD_RECOG_HI],
                  rx_machine_mode_r[alc_pkg::RMD_RECOG_LO]};
  assign ch = rx_char_in.data[7:0];
  assign is_addr = rx_char_in.data[8];
  assign prog_hit = (ch == match_char_0_r) || (ch == match_char_1_r);

  always_comb begin
    case (recog)
      2'b01: std_hit = (ch <= alc_pkg::ASCII_CTRL_TOP) ||
                       (ch == alc_pkg::ASCII_DEL);
      2'b11: std_hit = ch <= alc_pkg::EBCDIC_CTRL_TOP;
      default: std_hit = 1'b0;
    endcase
  end

  // only address characters are compared in multidrop mode
  assign match_hit = rx_char_in.valid &
                     (ulan ? (is_addr & prog_hit) : prog_hit);
  assign recog_hit = rx_char_in.valid &
                     (ulan ? is_addr : (prog_hit | std_hit));

  // status flags: read of status clears, a new hit wins over the clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      programmed_match_flag_r <= 1'b0;
      char_recognized_flag_r <= 1'b0;
    end else if (clk_en_in) begin
      programmed_match_flag_r <= match_hit |
                                 (programmed_match_flag_r & ~status_rd);
      char_recognized_flag_r <= recog_hit |
                                (char_recognized_flag_r & ~status_rd);
    end
  end

  // receive fifo lock in multidrop mode; software may relock
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_locked_r <= 1'b0;
    end else if (clk_en_in) begin
      if (!ulan) begin
        rx_locked_r <= 1'b0;
      end else if (rx_char_in.valid && is_addr && recog == 2'b01) begin
        rx_locked_r <= 1'b0;
      end else if (rx_char_in.valid && is_addr && recog == 2'b10) begin
        rx_locked_r <= ~prog_hit;
      end else if (wr_go && avs_address_in == alc_pkg::OFF_STATUS) begin
        rx_locked_r <= wbyte[3];
      end
    end
  end

  // mode 00 and 01 store address characters; mode 10 gates by match
  always_comb begin
    rx_fifo_write_out = 1'b0;
    if (rx_char_in.valid) begin
      if (!ulan) begin
        rx_fifo_write_out = 1'b1;
      end else if (is_addr) begin
        case (recog)
          2'b00: rx_fifo_write_out = 1'b1;
          2'b01: rx_fifo_write_out = 1'b1;
          2'b10: rx_fifo_write_out = prog_hit;
          default: rx_fifo_write_out = 1'b0;
        endcase
      end else begin
        rx_fifo_write_out = ~rx_locked_r;
      end
    end
  end

  // echo skips errored or recognised characters when asked
  assign echo_char_out = rx_char_in.valid &&
    (loop_mode_out == alc_pkg::ALC_LOOP_ECHO) &&
    !(rx_char_in.error && tx_machine_mode_r[alc_pkg::TMD_ERR_ECHO_OFF]) &&
    !(recog_hit && tx_machine_mode_r[alc_pkg::TMD_CTRL_ECHO_OFF]);

  assign rx_fifo_locked_out = rx_locked_r;

endmodule

// ### tb/alc_config_props.sv
// checker for the async line configuration block
// assumes it sees only the ports of alc_config, bound below
module alc_config_props (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // bus and pins
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic tx_serial_in,
  input wire logic tx_pin_out,
  // receive path and decoded config
  input alc_pkg::alc_rx_char_t rx_char_in,
  input wire logic rx_fifo_write_out,
  input wire logic echo_char_out,
  input wire logic rx_fifo_locked_out,
  input alc_pkg::alc_line_t line_cfg_out,
  input alc_pkg::alc_loop_t loop_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_BREAK_LOW: assert property (line_cfg_out.force_break |=>
    !tx_pin_out) else $error("tx pin not low during break");
  AST_PIN_FOLLOWS: assert property (!line_cfg_out.force_break |=>
    tx_pin_out == $past(tx_serial_in)) else $error("tx pin lost data");
  AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");
  AST_UPPER_ZERO: assert property (avs_read_in && !avs_waitrequest_out
    |-> avs_readdata_out[31:8] == 24'h0) else $error("upper bits set");
  AST_STOP_RANGE: assert property (line_cfg_out.stop_quarters
    inside {[4'h3:4'h8]}) else $error("stop length out of table");
  AST_WRITE_CAUSE: assert property (rx_fifo_write_out |->
    rx_char_in.valid) else $error("fifo write without a character");
  AST_ECHO_MODE: assert property (echo_char_out |-> rx_char_in.valid &&
    loop_mode_out == alc_pkg::ALC_LOOP_ECHO) else $error("echo out of mode");
  AST_LOCK_HOLDS: assert property (rx_fifo_locked_out &&
    rx_char_in.valid && !rx_char_in.data[8] |-> !rx_fifo_write_out)
    else $error("lock leaked");
  cover property (line_cfg_out.force_break);
  cover property (rx_fifo_write_out && rx_fifo_locked_out);
  cover property (echo_char_out);
endmodule
bind alc_config alc_config_props u_props (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .tx_serial_in(tx_serial_in),
  .tx_pin_out(tx_pin_out), .rx_char_in(rx_char_in),
  .rx_fifo_write_out(rx_fifo_write_out), .echo_char_out(echo_char_out),
  .rx_fifo_locked_out(rx_fifo_locked_out), .line_cfg_out(line_cfg_out),
  .loop_mode_out(loop_mode_out));

// ### tb/alc_remote_model.sv
// far-side serial peer: answers rts with cts, hands in characters
// assumes the bench calls put_char and drives stall_in
module alc_remote_model (
  // clock and control
  input wire logic clk_in,
  input wire logic stall_in,
  // line side
  input wire logic rts_n_in,
  input wire logic fifo_write_in,
  output logic cts_n_out,
  output alc_pkg::alc_rx_char_t rx_char_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cts_n_out = 1'b1;
  initial rx_char_out = '0;
  // cts a cycle late; a stall acts like a busy peer
  always @(posedge clk_in) cts_n_out <= rts_n_in | stall_in;
  // one character per call, valid for a single cycle
  task automatic put_char(input logic [8:0] d, output logic wr);
    @(posedge clk_in);
    rx_char_out <= '{1'b1, d, 1'b0};
    @(posedge clk_in);
    wr = fifo_write_in;
    rx_char_out <= '0;
  endtask
endmodule

// ### tb/alc_config_tb_top.sv
// self-checking bench for the async line configuration block
// assumes the checker is bound and the far side is alc_remote_model
module alc_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, ten = 0, more = 0, ser = 1;
  logic stall = 0, wrote, wreq, pin, rts_n, go, rxq, txq, fwr, lock, cts_n;
  logic [5:0] adr = 0;
  logic [31:0] wd = 0, q, rdata;
  logic [2:0] rxo = 0, txo = 0;
  logic [1:0] l;
  logic [7:0] t;
  logic [15:0] rnd = 16'h0003, da;
  logic [8:0] ch[9] = '{9'h05A, 9'h01F, 9'h07F, 9'h020, 9'h041, 9'h113,
    9'h055, 9'h112, 9'h055};
  logic [4:0] ex[9] = '{5'h13, 5'h11, 5'h11, 5'h10, 5'h13, 5'h09, 5'h08,
    5'h13, 5'h10};
  int error_cnt = 0, total_checks = 0;
  alc_pkg::alc_line_t lc;
  alc_pkg::alc_samp_t sc;
  alc_pkg::alc_loop_t lm;
  alc_pkg::alc_rx_char_t rxc;
  alc_config dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .tx_enabled_in(ten), .tx_more_data_in(more), .tx_serial_in(ser),
    .cts_n_in(cts_n), .host_rts_n_in(more), .tx_pin_out(pin),
    .rts_n_out(rts_n), .tx_go_out(go), .rx_occupancy_in(rxo),
    .tx_occupancy_in(txo), .rx_fifo_req_out(rxq), .tx_fifo_req_out(txq),
    .rx_char_in(rxc), .rx_fifo_write_out(fwr), .echo_char_out(),
    .rx_fifo_locked_out(lock), .line_cfg_out(lc), .samp_cfg_out(sc),
    .loop_mode_out(lm), .gen_a_divisor_out(da), .gen_b_divisor_out());
  alc_remote_model u_far (.clk_in(clk), .stall_in(stall), .rts_n_in(rts_n),
    .fifo_write_in(fwr), .cts_n_out(cts_n), .rx_char_out(rxc));
  // 125 MHz system clock
  always #4 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // 6/4 only for five-bit characters, else 8/4; codes 2 to 7 are linear
  function automatic logic [3:0] stop_q(input logic [2:0] c, input logic f);
    case (c)
      3'h0, 3'h3: return 4'h4;
      3'h1: return f ? 4'h6 : 4'h8;
      default: return {1'b0, c} + 4'h1;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one avalon cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 400 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
  // main sequence; config is only written while the line is idle
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      bus(0, 6'(i * 4), 8'h00);
      chk("reset", (i == 0) ? 32'h3 : 32'h0, q);
    end
    bus(1, 6'h00, 8'h83);
    bus(0, 6'h04, 8'h00);
    chk("div low", 32'h5, q);
    rnd = lfsr(rnd);
    bus(1, 6'h08, rnd[7:0]);
    bus(1, 6'h10, 8'hA5);
    chk("div a", {16'h0, rnd[7:0], 8'h05}, {16'h0, da});
    bus(1, 6'h00, 8'h03);
    bus(0, 6'h10, 8'h00);
    chk("match1", 32'h0, q);
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      l = (i == 8) ? 2'h0 : rnd[1:0];
      bus(1, 6'h00, {5'h00, i[0], l});
      bus(1, 6'h04, {2'h0, i == 8, 3'h0, i[2:1]});
      chk("bits", (i == 8) ? 4'h9 : 4'h5 + l, lc.char_bits);
      chk("stop", stop_q(i[2:0], l == 0 && i < 8), lc.stop_quarters);
    end
    for (int i = 0; i < 6; i++) begin
      bus(1, 6'h00, {2'h0, i < 4 ? i[1:0] : 2'h0, i != 4, 3'h3});
      bus(1, 6'h04, {5'h00, i == 5, 2'h0});
      chk("parity", i < 4 ? i + 1 : i == 4 ? 0 : 5, lc.parity);
    end
    bus(1, 6'h00, 8'h43);
    repeat (2) @(posedge clk);
    chk("break", 32'h0, pin);
    bus(1, 6'h00, 8'h03);
    repeat (2) @(posedge clk);
    chk("idle", 32'h1, pin);
    for (int i = 0; i < 4; i++) begin
      bus(1, 6'h1C, {5'h00, i[1:0], 1'b0});
      chk("loop", i == 0 ? 0 : i == 1 ? 3 : i - 1, lm);
    end
    rnd = lfsr(rnd);
    bus(1, 6'h14, {2'h0, rnd[2:0], 3'h0});
    bus(1, 6'h18, {rnd[6:3], 4'h0});
    chk("samp", {rnd[2:0], rnd[6:3]}, sc);
    $display("test format done");
    for (int i = 0; i < 48; i++) begin
      if (i % 16 == 0) bus(1, 6'h04, i < 16 ? 8'h10 : i < 32 ? 8'h18 : 8'h00);
      if (i % 4 == 0) t = 8'(lfsr(rnd)) & 8'h33;
      if (i % 4 == 0) bus(1, 6'h08, t);
      rnd = lfsr(rnd);
      {ten, more, stall} <= rnd[2:0];
      rxo <= rnd[8:6] % 3'h5;
      txo <= rnd[11:9] % 3'h5;
      repeat (2) @(posedge clk);
      chk("flow", i[5] ? more : !(ten & (!i[4] | more)), rts_n);
      chk("go", i[5] ? ten : ten && !cts_n, go);
      chk("req", {rxo > t[5:4], txo <= t[1:0]}, {rxq, txq});
    end
    $display("test flow done");
    rxo <= 3'h0;
    bus(1, 6'h0C, 8'h41);
    bus(1, 6'h10, 8'h5A);
    bus(1, 6'h14, 8'h40);
    for (int i = 0; i < 9; i++) begin
      if (i == 5) bus(1, 6'h1C, 8'h03);
      if (i == 5) bus(1, 6'h14, 8'h80);
      if (i == 5) bus(1, 6'h0C, 8'h12);
      u_far.put_char(ch[i], wrote);
      bus(0, 6'h20, 8'h00);
      chk("recog", ex[i], {wrote, q[3:0]});
    end
    $display("test recognition done");
    give_verdict;
  end
endmodule
